// ### sd_channel_pkg.sv
package sd_channel_pkg;
	localparam int NUM_CH_DEF = 7;
	localparam int IDX_W = 10;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CTL_BASE = 10'h102;
	localparam logic [IDX_W-1:0] IDX_IV = 10'h110;
	localparam logic [IDX_W-1:0] IDX_MEM_BASE = 10'h112;
	localparam logic [IDX_W-1:0] IDX_INCTL_BASE = 10'h0B0;
	localparam logic [IDX_W-1:0] IDX_AE = 10'h0B7;
	localparam logic [IDX_W-1:0] IDX_PRE_BASE = 10'h0B8;
	localparam logic [IDX_W-1:0] IDX_STEP_WIDE = 10'h002;

	// channel_control fields
	localparam int B_BUF = 13;
	localparam int B_UNI = 12;
	localparam int B_XOSR = 11;
	localparam int B_SNGL = 10;
	localparam int B_OSR = 8;
	localparam int B_TOG = 7;
	localparam int B_ACC = 6;
	localparam int B_OVF = 5;
	localparam int B_DF = 4;
	localparam int B_IE = 3;
	localparam int B_IFG = 2;
	localparam int B_SC = 1;
	localparam int B_GRP = 0;
	localparam logic [15:0] CTL_CFG_MASK = 16'h7F99;
	localparam logic [15:0] CTL_BUF_MASK = 16'h6000;

	// channel_input_control fields
	localparam int B_DLY = 6;
	localparam int B_GAIN = 3;
	localparam int B_INCH = 0;

	localparam logic [15:0] RST_CTL = 16'h0000;
	localparam logic [7:0] RST_INCTL = 8'h00;
	localparam logic [7:0] RST_PRE = 8'h00;
	localparam logic [7:0] RST_AE = 8'h00;
	localparam logic [7:0] RST_NEG_GND = 8'hFF;

	localparam logic [4:0] VEC_NONE = 5'h00;
	localparam logic [4:0] VEC_OVF = 5'h02;
	localparam logic [4:0] VEC_CH_BASE = 5'h04;
	localparam logic [1:0] FIRST_IRQ_MAX = 2'h3;
	localparam logic [2:0] GAIN_LAST = 3'h5;

	typedef struct packed {
		logic [1:0] input_buffer_mode;
		logic unipolar_select;
		logic single_shot_select;
		logic [10:0] oversample_ratio;
		logic ratio_reserved;
		logic running;
		logic group_with_next;
		logic result_format;
		logic [2:0] preamp_gain;
		logic gain_reserved;
		logic [2:0] input_pair_select;
		logic [7:0] filter_preload;
	} chan_cfg_s;

	function automatic logic [10:0] osr_decode(input logic xosr, input logic [1:0] code);
		logic [10:0] r;
		r = 11'h000;
		if (!xosr) begin
			r = 11'h100 >> code;
		end else if (code == 2'h0) begin
			r = 11'h200;
		end else if (code == 2'h1) begin
			r = 11'h400;
		end
		return r;
	endfunction
endpackage

// ### sd_channel_control.sv
`timescale 1ns/100ps
module sd_channel_control #(
	parameter int NUM_CH = sd_channel_pkg::NUM_CH_DEF,
	parameter bit HAS_BUFFER = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] sample_valid,
	input wire logic [NUM_CH-1:0][31:0] sample_data,
	input wire logic [NUM_CH-1:0] overflow_event,
	output sd_channel_pkg::chan_cfg_s [NUM_CH-1:0] chan_cfg,
	output logic [NUM_CH-1:0] conversion_start,
	output logic [7:0] analog_enable_bits,
	output logic [7:0] negative_to_ground
);
	import sd_channel_pkg::*;

	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [7:0] ae_q;
	logic [7:0] neg_gnd_q;
	logic [NUM_CH-1:0] start_q;
	chan_cfg_s [NUM_CH-1:0] cfg_out_q;

	wire [IDX_W-1:0] idx = paddr[11:2];
	wire acc_phase = psel & penable;
	// side effects only at the edge that completes the transfer
	wire done = acc_phase & pready_q;
	wire wr_en = done & pwrite;
	wire rd_en = done & ~pwrite;
	wire hit_ae = (idx == IDX_AE);
	wire hit_iv = (idx == IDX_IV);

	wire [NUM_CH-1:0] start_req;
	wire [NUM_CH-1:0] ovf_vec;
	wire [NUM_CH-1:0] pend_vec;
	wire [NUM_CH-1:0] hit_any;
	wire [NUM_CH-1:0][15:0] rd_ch;

	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			logic [15:0] cfg_q;
			logic acc_q;
			logic ovf_q;
			logic ifg_q;
			logic sc_q;
			logic [1:0] skip_q;
			logic [31:0] res_q;
			logic [7:0] inctl_q;
			logic [7:0] pre_q;

			wire [IDX_W-1:0] off_w = IDX_W'(i);
			wire [IDX_W-1:0] off_n = IDX_W'(2 * i);
			wire hit_ctl = (idx == IDX_CTL_BASE + off_n);
			wire hit_mem = (idx == IDX_MEM_BASE + off_n);
			wire hit_inctl = (idx == IDX_INCTL_BASE + off_w);
			wire hit_pre = (idx == IDX_PRE_BASE + off_w);
			wire wr_ctl = wr_en & hit_ctl;
			wire rd_mem = rd_en & hit_mem;
			wire [15:0] cfg_mask = HAS_BUFFER ? CTL_CFG_MASK : (CTL_CFG_MASK & ~CTL_BUF_MASK);
			wire single = cfg_q[B_SNGL];
			// grouping written together with the start bit already counts
			wire grp_now = wr_ctl ? pwdata[B_GRP] : cfg_q[B_GRP];
			wire chain_in;
			if (i == 0) begin : g_first
				assign chain_in = 1'b0;
			end else begin : g_rest
				// lower channel grouped with this one starts it too
				assign chain_in = start_req[i-1] & g_ch[i-1].grp_now;
			end
			assign start_req[i] = (wr_ctl & pwdata[B_SC]) | chain_in;
			// samples before the chosen one are swallowed
			wire deliver = sample_valid[i] & sc_q & (skip_q == 2'h0) & ~start_req[i];
			// offset binary from the filter; msb flip gives two's complement
			wire [31:0] res_fmt = cfg_q[B_DF] ? {~sample_data[i][31], sample_data[i][30:0]}
				: sample_data[i];
			// hardware sets win over same-cycle clears
			wire ifg_d = deliver | (wr_ctl ? pwdata[B_IFG] : (ifg_q & ~rd_mem));
			wire ovf_d = overflow_event[i] | (wr_ctl ? pwdata[B_OVF] : ovf_q);
			wire sc_d = start_req[i] | (wr_ctl ? pwdata[B_SC] : (sc_q & ~(deliver & single)));
			wire acc_d = wr_ctl ? pwdata[B_ACC] : (acc_q ^ (rd_mem & cfg_q[B_TOG]));
			wire [1:0] skip_d = start_req[i] ? (FIRST_IRQ_MAX - inctl_q[B_DLY +: 2])
				: (sample_valid[i] & sc_q & (skip_q != 2'h0)) ? skip_q - 2'h1 : skip_q;
			wire [15:0] window = acc_q ? res_q[15:0] : res_q[31:16];
			wire [15:0] ctl_rd = (cfg_q & cfg_mask) | (16'(acc_q) << B_ACC) | (16'(ovf_q) << B_OVF)
				| (16'(ifg_q) << B_IFG) | (16'(sc_q) << B_SC);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_q <= RST_CTL;
					acc_q <= 1'b0;
					ovf_q <= 1'b0;
					ifg_q <= 1'b0;
					sc_q <= 1'b0;
					skip_q <= 2'h0;
					res_q <= 32'h0000_0000;
					inctl_q <= RST_INCTL;
					pre_q <= RST_PRE;
				end else begin
					if (wr_ctl) begin
						cfg_q <= pwdata[15:0] & cfg_mask;
					end
					if (wr_en & hit_inctl) begin
						inctl_q <= pwdata[7:0];
					end
					if (wr_en & hit_pre) begin
						pre_q <= pwdata[7:0];
					end
					if (deliver) begin
						res_q <= res_fmt;
					end
					acc_q <= acc_d;
					ovf_q <= ovf_d;
					ifg_q <= ifg_d;
					sc_q <= sc_d;
					skip_q <= skip_d;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_out_q[i] <= '0;
				end else begin
					cfg_out_q[i].input_buffer_mode <= cfg_q[B_BUF +: 2] & {2{HAS_BUFFER}};
					cfg_out_q[i].unipolar_select <= cfg_q[B_UNI];
					cfg_out_q[i].single_shot_select <= single;
					cfg_out_q[i].oversample_ratio <= osr_decode(cfg_q[B_XOSR], cfg_q[B_OSR +: 2]);
					cfg_out_q[i].ratio_reserved <= cfg_q[B_XOSR] & cfg_q[B_OSR + 1];
					cfg_out_q[i].running <= sc_q;
					cfg_out_q[i].group_with_next <= (i < NUM_CH - 1) & cfg_q[B_GRP];
					cfg_out_q[i].result_format <= cfg_q[B_DF];
					cfg_out_q[i].preamp_gain <= inctl_q[B_GAIN +: 3];
					cfg_out_q[i].gain_reserved <= (inctl_q[B_GAIN +: 3] > GAIN_LAST);
					cfg_out_q[i].input_pair_select <= inctl_q[B_INCH +: 3];
					cfg_out_q[i].filter_preload <= pre_q;
				end
			end

			assign ovf_vec[i] = ovf_q;
			// disabled channel keeps its flag but raises no request
			assign pend_vec[i] = ifg_q & cfg_q[B_IE];
			assign hit_any[i] = hit_ctl | hit_mem | hit_inctl | hit_pre;
			assign rd_ch[i] = hit_ctl ? ctl_rd : hit_mem ? window
				: hit_inctl ? {8'h00, inctl_q} : hit_pre ? {8'h00, pre_q} : 16'h0000;
		end
	endgenerate

	// overflow ranks first, then the lowest pending channel
	logic [4:0] vec_w;
	always_comb begin
		vec_w = VEC_NONE;
		for (int c = NUM_CH - 1; c >= 0; c--) begin
			if (pend_vec[c]) begin
				vec_w = VEC_CH_BASE + 5'(2 * c);
			end
		end
		if (|ovf_vec) begin
			vec_w = VEC_OVF;
		end
	end

	logic [15:0] rd_word;
	always_comb begin
		rd_word = 16'h0000;
		for (int c = 0; c < NUM_CH; c++) begin
			rd_word = rd_word | rd_ch[c];
		end
		if (hit_ae) begin
			rd_word = {8'h00, ae_q};
		end
		if (hit_iv) begin
			rd_word = {11'h000, vec_w[4:1], 1'b0};
		end
	end

	wire mapped = (|hit_any) | hit_ae | hit_iv;

	// one wait state: data is captured on the same edge that raises pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= acc_phase & ~pready_q;
			pslverr_q <= acc_phase & ~pready_q & ~mapped;
			if (acc_phase & ~pready_q) begin
				prdata_q <= {16'h0000, rd_word};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ae_q <= RST_AE;
			neg_gnd_q <= RST_NEG_GND;
			start_q <= '0;
		end else begin
			if (wr_en & hit_ae) begin
				ae_q <= pwdata[7:0];
				neg_gnd_q <= ~pwdata[7:0];
			end
			start_q <= start_req;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign chan_cfg = cfg_out_q;
	assign conversion_start = start_q;
	assign analog_enable_bits = ae_q;
	assign negative_to_ground = neg_gnd_q;
endmodule

// ### sd_datapath_model.sv
`timescale 1ns/100ps
module sd_datapath_model #(
	parameter int NUM_CH = 7
) (
	input wire logic pclk,
	input wire logic fire,
	input wire logic ovf,
	input wire logic [2:0] ch,
	input wire logic [31:0] data,
	output logic [NUM_CH-1:0] sample_valid,
	output logic [NUM_CH-1:0][31:0] sample_data,
	output logic [NUM_CH-1:0] overflow_event
);
	logic [31:0] last = '0;
	initial begin
		sample_valid = '0;
		overflow_event = '0;
		sample_data = '0;
	end
	always @(posedge pclk) begin
		sample_valid <= '0;
		overflow_event <= '0;
		// data is not held outside a valid cycle
		sample_data <= {NUM_CH{~last}};
		if (fire) begin
			sample_valid[ch] <= 1'b1;
			sample_data[ch] <= data;
			last <= data;
		end
		if (ovf) begin
			overflow_event[ch] <= 1'b1;
		end
	end
endmodule

// ### sd_channel_control_asserts.sv
`timescale 1ns/100ps
module sd_channel_control_asserts
	import sd_channel_pkg::*;
#(
	parameter int NUM_CH = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire sd_channel_pkg::chan_cfg_s [NUM_CH-1:0] chan_cfg,
	input wire logic [NUM_CH-1:0] conversion_start,
	input wire logic [7:0] analog_enable_bits,
	input wire logic [7:0] negative_to_ground
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_done;
		psel && penable && pready;
	endsequence
	sequence s_iv_rd;
		s_done ##0 (!pwrite && paddr[11:2] == IDX_IV);
	endsequence
	sequence s_go0;
		s_done ##0 (pwrite && paddr[11:2] == IDX_CTL_BASE && pwdata[B_SC] && !chan_cfg[0].running);
	endsequence
	AST_IV_ZERO: assert property (s_iv_rd |-> prdata[31:5] == '0 && !prdata[0])
		else $error("vector spare bits set");
	AST_IV_CODE: assert property (s_iv_rd |-> prdata[4:0] <= 5'h10)
		else $error("vector code out of range");
	AST_START: assert property (s_go0 |-> ##[1:2] conversion_start[0])
		else $error("no start pulse");
	AST_NEG_GND: assert property (negative_to_ground == ~analog_enable_bits)
		else $error("negative ground mismatch");
	AST_LAST_GRP: assert property (!chan_cfg[NUM_CH-1].group_with_next)
		else $error("last channel grouped");
	// config outputs hold all zeros for one edge after reset, before the decode lands
	AST_RATIO: assert property ($past(presetn) |->
		chan_cfg[0].ratio_reserved == (chan_cfg[0].oversample_ratio == '0))
		else $error("ratio reserved mismatch");
	AST_GAIN: assert property (chan_cfg[0].gain_reserved == (chan_cfg[0].preamp_gain > GAIN_LAST))
		else $error("gain reserved mismatch");
	AST_RESET: assert property ($rose(presetn) |-> conversion_start == '0 && analog_enable_bits == '0)
		else $error("not clear after reset");
endmodule
bind sd_channel_control sd_channel_control_asserts #(.NUM_CH(NUM_CH)) u_asserts (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .chan_cfg, .conversion_start,
	.analog_enable_bits, .negative_to_ground);

// ### sd_channel_control_tb_top.sv
`timescale 1ns/100ps
module sd_channel_control_tb_top;
	import sd_channel_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, ovf = 0;
	logic pready, pslverr, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, data = '0, prdata, rd;
	logic [2:0] ch = '0;
	logic [6:0] sv, oe, cs, seen = '0;
	logic [6:0][31:0] sdat;
	logic [7:0] ae, ng;
	chan_cfg_s [6:0] cfg;
	int error_cnt = 0, samples_checked = 0;
	logic [10:0] ratio [8] = '{11'h100, 11'h080, 11'h040, 11'h020, 11'h200, 11'h400, 0, 0};
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) seen <= seen | cs;
	sd_channel_control i_sd_channel_control (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sample_valid(sv), .sample_data(sdat),
		.overflow_event(oe), .chan_cfg(cfg), .conversion_start(cs), .analog_enable_bits(ae),
		.negative_to_ground(ng));
	sd_datapath_model u_model (.pclk, .fire, .ovf, .ch, .data, .sample_valid(sv),
		.sample_data(sdat), .overflow_event(oe));
	task automatic conclude();
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'h0};
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// config outputs lag the registers by a cycle
		repeat (2) @(posedge pclk);
		if (n >= 20) error_cnt++;
	endtask
	task automatic rc(input string nm, input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(nm, e, rd);
	endtask
	task automatic pulse(input logic [2:0] c, input logic [31:0] d, input logic o);
		ch <= c;
		data <= d;
		fire <= !o;
		ovf <= o;
		@(posedge pclk) fire <= 1'b0;
		ovf <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("ctl", IDX_CTL_BASE, 0);
		rc("inctl", IDX_INCTL_BASE, 0);
		rc("iv", IDX_IV, 0);
		apb(1, IDX_CTL_BASE, 32'hFF99);
		rc("ctl", IDX_CTL_BASE, 32'h7F99);
		chk("buf", 2'h3, cfg[0].input_buffer_mode);
		chk("uni", 1, cfg[0].unipolar_select);
		chk("sngl", 1, cfg[0].single_shot_select);
		chk("rres", 1, cfg[0].ratio_reserved);
		chk("fmt", 1, cfg[0].result_format);
		chk("gout", 1, cfg[0].group_with_next);
		for (int i = 0; i < 8; i++) begin
			apb(1, IDX_CTL_BASE, {20'h0, i[2], 1'b0, i[1:0], 8'h00});
			chk("ratio", ratio[i], cfg[0].oversample_ratio);
			apb(1, IDX_INCTL_BASE, i * 9);
			chk("gain", i, cfg[0].preamp_gain);
			chk("gres", i > 5, cfg[0].gain_reserved);
			chk("inch", i, cfg[0].input_pair_select);
		end
		apb(1, IDX_AE, 32'h5A);
		chk("ng", 8'hA5, ng);
		chk("ae", 8'h5A, ae);
		rc("aerd", IDX_AE, 32'h5A);
		apb(1, IDX_PRE_BASE, 32'hC3);
		chk("pre", 8'hC3, cfg[0].filter_preload);
		apb(0, 10'h3FF, 0);
		chk("err", 1, er);
		apb(1, IDX_INCTL_BASE, 32'h80);
		apb(1, IDX_CTL_BASE, 32'h9B);
		pulse(0, 32'hFFFF_0000, 0);
		rc("iv", IDX_IV, 0);
		pulse(0, 32'h8000_1234, 0);
		chk("grp", 7'h03, seen);
		rc("iv", IDX_IV, 4);
		apb(1, IDX_CTL_BASE, 32'h95);
		rc("iv", IDX_IV, 0);
		apb(1, IDX_CTL_BASE, 32'h9D);
		rc("iv", IDX_IV, 4);
		pulse(4, 0, 1);
		rc("iv", IDX_IV, 2);
		rc("ovf4", IDX_CTL_BASE + 8, 32'h20);
		apb(1, IDX_CTL_BASE + 8, 0);
		rc("iv", IDX_IV, 4);
		rc("hi", IDX_MEM_BASE, 0);
		rc("lo", IDX_MEM_BASE, 32'h1234);
		rc("iv", IDX_IV, 0);
		conclude();
	end
	initial begin
		#10000;
		error_cnt++;
		conclude();
	end
endmodule
